// file: core/sgc_top.sv
// Purpose: Paged registers and per-loop frame clock gating
// Assumes: Register port carries decoded accesses from the serial host port
// Notes: Read data appears one cycle after reg_rd with reg_rvalid
`timescale 1ns/10ps
`include "sgc_regs.svh"
module sgc_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic trigger_flex_pin,
   input wire logic [`SGC_NUM_LOOPS-1:0] frame_clk_in,
   output sgc_pkg::sgc_outs_t clk_out,
   output logic [`SGC_NUM_LOOPS-1:0] gate_open
);
   import sgc_pkg::*;
   sgc_top_state_t s_q;
   sgc_top_state_t s_d;
   logic [`SGC_NUM_LOOPS-1:0] req;

   // Maps the page register to a loop; bit 2 flags a loop page
   function automatic logic [2:0] loop_of_page(input logic [7:0] pg);
      logic [7:0] diff;
      diff = pg - `SGC_PAGE_LOOP_BASE;
      if (pg >= `SGC_PAGE_LOOP_BASE && diff < 8'(`SGC_NUM_LOOPS)) begin
         loop_of_page = {1'b1, diff[1:0]};
      end else begin
         loop_of_page = 3'h0;
      end
   endfunction

   localparam logic [3:0] TGT_PAGE = 4'h1;
   localparam logic [3:0] TGT_PIN_EN = 4'h2;
   localparam logic [3:0] TGT_TRIG = 4'h4;
   localparam logic [3:0] TGT_SEL = 4'h8;

   // One decode serves write and read, so the two can never disagree
   function automatic logic [3:0] target_of(input logic [7:0] addr,
      input logic [7:0] pg);
      logic [2:0] lsel;
      lsel = loop_of_page(pg);
      target_of = 4'h0;
      if (addr == `SGC_PAGE_ADDR) begin
         target_of = TGT_PAGE;
      end else if (pg == `SGC_PAGE_GEN) begin
         if (addr == `SGC_PIN_EN_ADDR) begin
            target_of = TGT_PIN_EN;
         end
      end else if (lsel[2]) begin // see (R12)
         if (addr == `SGC_LOOP_TRIG_ADDR) begin
            target_of = TGT_TRIG;
         end else if (addr == `SGC_LOOP_SEL_ADDR) begin
            target_of = TGT_SEL;
         end
      end
   endfunction

   always_comb begin
      logic [2:0] lp;
      logic [3:0] tgt;
      lp = loop_of_page(s_q.page);
      tgt = target_of(reg_addr, s_q.page);
      s_d = s_q;
      // Pin is only two flops deep, so latency is two cycles
      s_d.sync1 = trigger_flex_pin; // see (R13)
      s_d.sync2 = s_q.sync1; // see (R13)
      s_d.rvalid = reg_rd;
      if (reg_wr) begin
         case (tgt)
            TGT_PAGE: begin
               s_d.page = reg_wdata; // see (R12)
            end
            TGT_PIN_EN: begin
               // Stored as written; bits 7:6 hold unless software changes them
               s_d.pin_en = reg_wdata; // see (R1) see (R4)
            end
            TGT_TRIG: begin
               s_d.trig[lp[1:0]] = reg_wdata; // see (R5)
            end
            TGT_SEL: begin
               s_d.sel[lp[1:0]] = reg_wdata[`SGC_NUM_OUTS-1:0]; // see (R11)
            end
            default: begin
               s_d.page = s_q.page;
            end
         endcase
      end
      if (reg_rd) begin
         case (tgt)
            TGT_PAGE: begin
               s_d.rdata = s_q.page;
            end
            TGT_PIN_EN: begin
               s_d.rdata = s_q.pin_en;
            end
            TGT_TRIG: begin
               // Trigger reads back as stored so read-modify-write is safe
               s_d.rdata = s_q.trig[lp[1:0]]; // see (R8)
            end
            TGT_SEL: begin
               s_d.rdata = {2'b00, s_q.sel[lp[1:0]]};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.page <= `SGC_PAGE_GEN;
         s_q.pin_en <= `SGC_PIN_EN_RST; // see (R4)
         s_q.trig <= {`SGC_NUM_LOOPS{`SGC_LOOP_TRIG_RST}};
         s_q.sel <= {`SGC_NUM_LOOPS{`SGC_LOOP_SEL_RST}};
         s_q.sync1 <= 1'b0;
         s_q.sync2 <= 1'b0;
         s_q.rdata <= 8'h00;
         s_q.rvalid <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   generate
      for (genvar i = 0; i < `SGC_NUM_LOOPS; i++) begin : g_loop
         sgc_loop_if lif ();
         // Pin and software triggers are ORed: either opens the gate
         assign req[i] = (s_q.pin_en[i] & s_q.sync2) // see (R1)
                       | s_q.trig[i][`SGC_SW_TRIG_BIT]; // see (R6) see (R7)
         assign lif.req = req[i];
         assign lif.frame_clk = frame_clk_in[i];
         assign lif.sel = s_q.sel[i];
         assign clk_out[i] = lif.out;
         assign gate_open[i] = lif.open;
         sgc_gate u_gate (
            .clk(clk),
            .reset_n(reset_n),
            .lp(lif.gate)
         );
      end
   endgenerate

   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
endmodule

// file: core/sgc_regs.svh
// Purpose: Register map, field positions, reset values of the gating block
// Assumes: 8-bit paged register map, page select visible on every page
// Notes: How it works list below
// How it works
// (R1) Trigger-enable bits 0..3 let the flex pin gate loops A..D.
// (R2) Software writes trigger-enable bit 4 as zero.
// (R3) Software writes trigger-enable bit 5 as one.
// (R4) Trigger-enable bits 7:6 reset to zero; software preserves them.
// (R5) Loop register loop_sysref_trigger_control bit 1 is the software trigger for that loop.
// (R6) Software trigger at one passes the frame clock to the selected output.
// (R7) Software trigger at zero stops the frame clock on that output.
// (R8) Software toggles bit 1 by read-modify-write of loop register loop_sysref_trigger_control.
// (R9) Request high passes the frame clock; low holds the output high.
// (R10) Gate opens and closes only on a frame clock rising edge.
// (R11) Loop register 0x09 bits 5:0 pick the output, one-hot.
// (R12) Register 0xFF selects page; 0x00 general, loop page before loop access.
// (R13) Flex pin passes two flip-flops before it steers the gate.
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH
`define SGC_NUM_LOOPS 4
`define SGC_NUM_OUTS 6
`define SGC_PAGE_ADDR 8'hFF
`define SGC_PAGE_GEN 8'h00
`define SGC_PAGE_LOOP_BASE 8'h0A
`define SGC_PIN_EN_ADDR 8'h19
`define SGC_PIN_EN_RST 8'h20
`define SGC_LOOP_TRIG_ADDR 8'h05
`define SGC_LOOP_TRIG_RST 8'h00
`define SGC_SW_TRIG_BIT 1
`define SGC_LOOP_SEL_ADDR 8'h09
`define SGC_LOOP_SEL_RST 6'h00
`endif

// file: core/sgc_pkg.sv
// Purpose: Types shared by the gating block modules
// Assumes: Constants come from sgc_regs.svh
// Notes: State of each module is one packed struct
`include "sgc_regs.svh"
package sgc_pkg;
   typedef logic [`SGC_NUM_OUTS-1:0] sgc_sel_t;
   typedef logic [`SGC_NUM_LOOPS-1:0][`SGC_NUM_OUTS-1:0] sgc_outs_t;
   typedef enum logic [1:0] {
      SGC_GATE_CLOSED = 2'b01,
      SGC_GATE_OPEN = 2'b10
   } sgc_gate_st_t;
   typedef struct packed {
      sgc_gate_st_t st;
      logic clk_prev;
      sgc_sel_t out;
   } sgc_gate_state_t;
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] pin_en;
      logic [`SGC_NUM_LOOPS-1:0][7:0] trig;
      logic [`SGC_NUM_LOOPS-1:0][`SGC_NUM_OUTS-1:0] sel;
      logic sync1;
      logic sync2;
      logic [7:0] rdata;
      logic rvalid;
   } sgc_top_state_t;
endpackage

// file: core/sgc_loop_if.sv
// Purpose: Carrier between register side and one loop gate
// Assumes: Single clock
// Notes: One instance per synthesis loop
`timescale 1ns/10ps
interface sgc_loop_if;
   logic req;
   logic frame_clk;
   sgc_pkg::sgc_sel_t sel;
   sgc_pkg::sgc_sel_t out;
   logic open;
   modport ctl (output req, output frame_clk, output sel,
                input out, input open);
   modport gate (input req, input frame_clk, input sel,
                 output out, output open);
endinterface

// file: core/sgc_gate.sv
// Purpose: Gates one loop's frame clock onto its selected output
// Assumes: Frame clock arrives as a level sampled on clk
// Notes: Unselected outputs and closed gate both sit at logic high
`timescale 1ns/10ps
`include "sgc_regs.svh"
module sgc_gate (
   input wire logic clk,
   input wire logic reset_n,
   sgc_loop_if.gate lp
);
   import sgc_pkg::*;
   sgc_gate_state_t s_q;
   sgc_gate_state_t s_d;
   logic rise;

   always_comb begin
      s_d = s_q;
      rise = lp.frame_clk & ~s_q.clk_prev;
      s_d.clk_prev = lp.frame_clk;
      // Changing state only at a rising edge keeps every pulse whole
      if (rise) begin // see (R10)
         case (s_q.st)
            SGC_GATE_CLOSED: begin
               if (lp.req) begin // see (R6) see (R9)
                  s_d.st = SGC_GATE_OPEN;
               end
            end
            SGC_GATE_OPEN: begin
               if (!lp.req) begin // see (R7) see (R9)
                  s_d.st = SGC_GATE_CLOSED;
               end
            end
            default: begin
               s_d.st = SGC_GATE_CLOSED;
            end
         endcase
      end
      for (int k = 0; k < `SGC_NUM_OUTS; k++) begin
         // Closed gate holds high; open gate follows the frame clock
         if (lp.sel[k] && s_d.st == SGC_GATE_OPEN) begin // see (R11) see (R9)
            s_d.out[k] = lp.frame_clk;
         end else begin
            s_d.out[k] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.st <= SGC_GATE_CLOSED;
         // Starting high hides a false rise when reset ends mid-pulse
         s_q.clk_prev <= 1'b1;
         s_q.out <= {`SGC_NUM_OUTS{1'b1}};
      end else begin
         s_q <= s_d;
      end
   end

   assign lp.out = s_q.out;
   assign lp.open = (s_q.st == SGC_GATE_OPEN);
endmodule

// file: verif/sgc_top_assertions.sv
// Purpose: Port checks of sgc_top
// Assumes: Frame clock slow (4 high, 4 low), output selected before opening
// Notes: Bound to sgc_top below
`timescale 1ns/10ps
module sgc_top_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [3:0] frame_clk_in,
   input wire sgc_pkg::sgc_outs_t clk_out,
   input wire logic [3:0] gate_open
);
   import sgc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_pg_wr;
      reg_wr && !reg_rd && reg_addr == 8'hFF;
   endsequence
   sequence s_pg_rd;
      reg_rd && !reg_wr && reg_addr == 8'hFF;
   endsequence
   property p_pg;
      s_pg_wr ##1 s_pg_rd |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_pg: assert property (p_pg) else $error("page readback");
   property p_rv;
      reg_rd |=> reg_rvalid;
   endproperty
   a_rv: assert property (p_rv) else $error("no rvalid");
   property p_norv;
      !reg_rd |=> !reg_rvalid;
   endproperty
   a_norv: assert property (p_norv) else $error("stray rvalid");
   property p_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("rdata moved");
   property p_unmap;
      reg_rd && reg_addr == 8'h33 |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped rd");
   // Gate moves exactly one cycle after a sampled frame clock rise
   property p_edge;
      $changed(gate_open[1]) |->
         $past(frame_clk_in[1]) && !$past(frame_clk_in[1], 2);
   endproperty
   a_edge: assert property (p_edge) else $error("gate off edge");
   property p_shut;
      !gate_open[1] && !$past(gate_open[1]) |-> clk_out[1] == 6'h3F;
   endproperty
   a_shut: assert property (p_shut) else $error("closed not high");
   property p_pass;
      gate_open[1] && $past(gate_open[1]) && !$past(frame_clk_in[1])
         && !$past(frame_clk_in[1], 2) |-> clk_out[1] != 6'h3F;
   endproperty
   a_pass: assert property (p_pass) else $error("open no clock");
endmodule
bind sgc_top sgc_top_chk u_chk (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .frame_clk_in(frame_clk_in), .clk_out(clk_out), .gate_open(gate_open));

// file: verif/sgc_fpga_req.sv
// Purpose: FPGA side raising the frame reference request
// Assumes: Request is a level held for len cycles
// Notes: Changes on falling clk edges, unrelated to the frame clock
`timescale 1ns/10ps
module sgc_fpga_req (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] len,
   output logic trigger_flex_pin
);
   logic go_q = 1'b0;
   logic [7:0] cnt_q = 8'h00;
   // Go is caught on the rising edge so the falling-edge update never
   // races the bench, which also moves its signals on the falling edge
   always @(posedge clk) go_q <= go;
   always @(negedge clk) begin
      if (go_q) cnt_q <= len;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
   assign trigger_flex_pin = cnt_q != 8'h00;
endmodule

// file: verif/test_sysref_gating_control.sv
// Purpose: Register and gating tests of sgc_top
// Assumes: Loop B, output bit 3 selected
// Notes: Inputs move on the falling edge
`timescale 1ns/10ps
module test_sysref_gating_control;
   import sgc_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic go = 1'b0, reg_rvalid, pin;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fcnt = 8'h00;
   logic [3:0] gate_open;
   sgc_outs_t clk_out;
   int miscompares = 0, num_checks = 0;
   int lows = 0, highs = 0;
   sgc_top dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .trigger_flex_pin(pin), .frame_clk_in({4{fcnt[2]}}),
      .clk_out(clk_out), .gate_open(gate_open));
   sgc_fpga_req fpga (.clk(clk), .go(go), .len(8'h28),
      .trigger_flex_pin(pin));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(negedge clk) fcnt <= fcnt + 8'h01;
   task automatic complete_run();
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR %0t got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask
   // Read compares d as expected data; write sends d
   task automatic acc(input logic [7:0] a, input logic [7:0] d,
      input logic rd);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = !rd;
      reg_rd = rd;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      if (rd) chk(reg_rdata, d);
      if (rd) chk({7'h00, reg_rvalid}, 8'h01);
   endtask
   // Write, then read back in the very next cycle with no idle cycle
   task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata, d);
   endtask
   // Reads a register and writes it back with only the masked bits changed
   task automatic rmw(input logic [7:0] a, input logic [7:0] m,
      input logic on);
      logic [7:0] v;
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      v = reg_rdata;
      acc(a, on ? (v | m) : (v & ~m), 1'b0);
   endtask
   task automatic wait_gate(input logic exp);
      int n;
      n = 0;
      while (gate_open[1] !== exp && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk({7'h00, gate_open[1]}, {7'h00, exp});
      if (n == 60) complete_run();
   endtask
   initial begin
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      acc(8'hFF, 8'h00, 1'b1);
      acc(8'h19, 8'h20, 1'b1);
      acc(8'h33, 8'h00, 1'b1);
      acc(8'h19, 8'h22, 1'b0);
      acc(8'h19, 8'h22, 1'b1);
      wr_then_rd(8'hFF, 8'h0D);
      acc(8'h09, 8'hC1, 1'b0);
      acc(8'h09, 8'h01, 1'b1);
      acc(8'hFF, 8'h0E, 1'b0);
      acc(8'h09, 8'h00, 1'b1);
      wr_then_rd(8'hFF, 8'h0B);
      acc(8'h05, 8'h00, 1'b1);
      acc(8'h09, 8'h00, 1'b1);
      acc(8'h09, 8'h08, 1'b0);
      acc(8'h09, 8'h08, 1'b1);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      chk({7'h00, gate_open[1]}, 8'h00);
      wait_gate(1'b1);
      chk({7'h00, gate_open[0]}, 8'h00);
      wait_gate(1'b0);
      chk({2'b00, clk_out[1]}, 8'h3F);
      acc(8'hFF, 8'h00, 1'b0);
      acc(8'h19, 8'h20, 1'b0);
      acc(8'hFF, 8'h0B, 1'b0);
      rmw(8'h05, 8'h02, 1'b1);
      acc(8'h05, 8'h02, 1'b1);
      wait_gate(1'b1);
      // Open gate copies the 4-high, 4-low frame clock onto output bit 3
      repeat (16) begin
         @(negedge clk);
         if (clk_out[1] == 6'h37) lows++;
         if (clk_out[1] == 6'h3F) highs++;
      end
      chk(8'(lows), 8'h08);
      chk(8'(highs), 8'h08);
      rmw(8'h05, 8'h02, 1'b0);
      wait_gate(1'b0);
      chk({2'b00, clk_out[1]}, 8'h3F);
      complete_run();
   end
endmodule
